// ===== logic/lp_if.sv
// Signals between the pin logic and the low-power wake unit
`timescale 1ns/1ns
interface lp_if;
  logic nmi_n;
  logic ring;
  logic txd;
  logic host_sel_n;
  logic host_wr_n;
  logic [5:1] enables;
  logic sleep_req;
  logic stop_req;
  logic wake;
  logic low_power;
  modport ctrl (output nmi_n, ring, txd, host_sel_n, host_wr_n, enables, sleep_req, stop_req,
                input wake, low_power);
  modport unit (input nmi_n, ring, txd, host_sel_n, host_wr_n, enables, sleep_req, stop_req,
                output wake, low_power);
endinterface

// ===== logic/mcu_expansion_bus_and_wake.sv
// Expansion bus, reset, nmi, low-power wake and emulation pin logic
//
// Overview of operation
// [RULE_01] Address outputs float during reset
// [RULE_02] Top address lines follow bank bits 0-2
// [RULE_03] Eight-bit two-way data bus, floats in reset
// [RULE_04] Write strobe low stores data, high in reset
// [RULE_05] Read strobe low fetches data, high in reset
// [RULE_06] Reset pin resets all; vector fetch follows
// [RULE_07] Nmi falling edge taken at instruction end
// [RULE_08] Sleep wakes on low nmi level
// [RULE_09] Stop wakes after twelve low nmi cycles
// [RULE_10] Enabled ring high level wakes
// [RULE_11] Enabled host select and write low wakes
// [RULE_12] Enabled serial line low wakes
// [RULE_13] Enabled terminal ready low wakes
// [RULE_14] Enabled line alert low wakes
// [RULE_15] Emulation pin high: normal mode, internal rom
// [RULE_16] Normal mode hides internal page reads
// [RULE_17] Emulation mode sends program fetches external
// [RULE_18] Emulation shows internal data on data bus
// [RULE_19] Fetch indicator high on opcode fetch cycles
// [RULE_20] Bus phase clock follows strobe phase
// [RULE_21] Qualified wake condition resumes execution
`timescale 1ns/1ns
module mcu_expansion_bus_and_wake #(
  parameter int STROBE_CYCLES = xbus_pkg::STROBE_CYCLES_DEFAULT
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_reset_in_n,
  // Processor access port
  input wire logic i_cpu_req,
  input wire logic i_cpu_we,
  input wire logic i_cpu_opfetch,
  input wire logic i_cpu_progfetch,
  input wire logic [15:0] i_cpu_addr,
  input wire logic [7:0] i_cpu_wdata,
  input wire logic [7:0] i_internal_rdata,
  input wire logic [2:0] i_bank_map_bit,
  input wire logic i_instr_done,
  output logic o_cpu_busy,
  output logic o_cpu_rvalid,
  output logic [7:0] o_cpu_rdata,
  // Interrupt and reset sequencing
  input wire logic i_nmi_n,
  output logic o_nmi_take,
  output logic o_reset_vector_fetch,
  // Low-power control
  input wire logic [7:0] i_low_power_control,
  input wire logic i_sleep_req,
  input wire logic i_stop_req,
  input wire logic i_ring_detect_in,
  input wire logic i_serial_tx_line,
  input wire logic i_host_select_in,
  input wire logic i_host_write_in,
  output logic o_low_power,
  output logic o_wake,
  // Mode
  input wire logic i_emulation_select_n,
  output logic o_rom_enable,
  output logic o_fetch_indicator,
  output logic o_bus_phase_clock_out,
  // Expansion bus pins
  output logic [15:0] o_addr,
  output logic o_addr_oe_n,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe_n,
  output logic o_bus_write_strobe_n,
  output logic o_bus_read_strobe_n
);
  initial begin
    if (STROBE_CYCLES < xbus_pkg::STROBE_CYCLES_MIN || STROBE_CYCLES > xbus_pkg::STROBE_CYCLES_MAX)
      $error("STROBE_CYCLES out of range");
  end

  logic [xbus_pkg::PIN_COUNT-1:0] pin_s;
  logic rst;
  logic rst_d_r;
  logic nmi_prev_r;
  logic nmi_pend_r;
  logic nmi_edge;
  logic emu_normal;
  logic [7:0] page;
  logic is_internal;
  logic go_ext;
  logic go_show;
  logic go_drive;
  xbus_pkg::bus_state_t bus_r;
  logic [3:0] strobe_cnt_r;
  logic ext_r;
  logic we_r;
  logic [7:0] int_data_r;
  lp_if lp ();

  // Data lanes are only sampled late in the strobe, after the two-flop delay
  pin_sync #(
    .W(xbus_pkg::PIN_COUNT),
    .RESET_VAL(xbus_pkg::PIN_RESET_VAL)
  ) u_pin_sync (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_pins({i_data, i_emulation_select_n, i_host_write_in, i_host_select_in,
             i_serial_tx_line, i_ring_detect_in, i_nmi_n, i_reset_in_n}),
    .o_sync(pin_s)
  );

  assign rst = i_reset | ~pin_s[xbus_pkg::PIN_RESET]; // [RULE_06]
  assign emu_normal = pin_s[xbus_pkg::PIN_EMU];
  assign nmi_edge = nmi_prev_r & ~pin_s[xbus_pkg::PIN_NMI];

  assign lp.nmi_n = pin_s[xbus_pkg::PIN_NMI];
  assign lp.ring = pin_s[xbus_pkg::PIN_RING];
  assign lp.txd = pin_s[xbus_pkg::PIN_TXD];
  assign lp.host_sel_n = pin_s[xbus_pkg::PIN_HOST_SEL];
  assign lp.host_wr_n = pin_s[xbus_pkg::PIN_HOST_WR];
  assign lp.enables = i_low_power_control[5:1];
  assign lp.sleep_req = i_sleep_req;
  assign lp.stop_req = i_stop_req;

  wake_unit u_wake_unit (
    .i_core_clk(i_core_clk),
    .i_rst(rst),
    .lp(lp)
  );

  // Access classification at request time
  assign page = i_cpu_addr[15:8];
  assign is_internal = page < xbus_pkg::INTERNAL_PAGE_END;
  // Internal rom only in normal mode; emulation sends program fetches out
  assign go_ext = !is_internal && !(page >= xbus_pkg::ROM_BASE_PAGE && emu_normal
                                    && !(i_cpu_progfetch && !emu_normal)); // [RULE_15] [RULE_16] [RULE_17]
  assign go_show = go_ext || (!emu_normal && is_internal); // [RULE_18]
  assign go_drive = i_cpu_we ? go_show : (!emu_normal && page < xbus_pkg::EMU_DATA_PAGE_END); // [RULE_18]

  // Vector fetch pulse on the first cycle after reset releases
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rst_d_r <= 1'b1;
      o_reset_vector_fetch <= 1'b0;
    end else begin
      rst_d_r <= rst;
      o_reset_vector_fetch <= rst_d_r & ~rst; // [RULE_06]
    end
  end

  // Nmi pending: an edge in the taking cycle is consumed, never lost
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      nmi_prev_r <= 1'b1;
      nmi_pend_r <= 1'b0;
      o_nmi_take <= 1'b0;
    end else begin
      nmi_prev_r <= pin_s[xbus_pkg::PIN_NMI];
      nmi_pend_r <= (nmi_pend_r | nmi_edge) & ~i_instr_done; // [RULE_07]
      o_nmi_take <= (nmi_pend_r | nmi_edge) & i_instr_done; // [RULE_07]
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      o_low_power <= 1'b0;
      o_wake <= 1'b0;
      o_rom_enable <= 1'b1;
    end else begin
      o_low_power <= lp.low_power;
      o_wake <= lp.wake; // [RULE_21]
      o_rom_enable <= emu_normal; // [RULE_15] [RULE_17]
    end
  end

  // Bus cycle sequencer
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      bus_r <= xbus_pkg::BS_IDLE;
      strobe_cnt_r <= 4'h0;
      ext_r <= 1'b0;
      we_r <= 1'b0;
      int_data_r <= 8'h00;
      o_cpu_busy <= 1'b0;
      o_cpu_rvalid <= 1'b0;
      o_cpu_rdata <= 8'h00;
      o_fetch_indicator <= 1'b0;
      o_bus_phase_clock_out <= 1'b0;
      o_addr <= 16'h0000;
      o_addr_oe_n <= 1'b1; // [RULE_01]
      o_data <= 8'h00;
      o_data_oe_n <= 1'b1; // [RULE_03]
      o_bus_write_strobe_n <= 1'b1; // [RULE_04]
      o_bus_read_strobe_n <= 1'b1; // [RULE_05]
    end else begin
      o_cpu_rvalid <= 1'b0;
      unique case (bus_r)
        xbus_pkg::BS_IDLE: begin
          if (i_cpu_req) begin
            o_cpu_busy <= 1'b1;
            ext_r <= go_ext;
            we_r <= i_cpu_we;
            int_data_r <= i_internal_rdata;
            o_fetch_indicator <= i_cpu_opfetch; // [RULE_19]
            if (go_show) begin
              bus_r <= xbus_pkg::BS_ADDR;
              o_addr <= {i_bank_map_bit, i_cpu_addr[xbus_pkg::BANK_ADDR_LSB-1:0]}; // [RULE_02]
              o_addr_oe_n <= 1'b0;
              o_data <= i_cpu_we ? i_cpu_wdata : i_internal_rdata; // [RULE_18]
              o_data_oe_n <= ~go_drive; // [RULE_03]
            end else begin
              bus_r <= xbus_pkg::BS_DONE; // [RULE_16]
            end
          end
        end
        xbus_pkg::BS_ADDR: begin
          bus_r <= xbus_pkg::BS_STROBE;
          strobe_cnt_r <= 4'(STROBE_CYCLES - 1);
          // Strobes only for real external cycles; shown internal cycles keep them high
          o_bus_write_strobe_n <= ~(ext_r & we_r); // [RULE_04]
          o_bus_read_strobe_n <= ~(ext_r & ~we_r); // [RULE_05]
          o_bus_phase_clock_out <= 1'b1; // [RULE_20]
        end
        xbus_pkg::BS_STROBE: begin
          if (strobe_cnt_r == 4'h0) begin
            bus_r <= xbus_pkg::BS_DONE;
            o_bus_write_strobe_n <= 1'b1;
            o_bus_read_strobe_n <= 1'b1;
            o_bus_phase_clock_out <= 1'b0; // [RULE_20]
            if (ext_r && !we_r) begin
              int_data_r <= pin_s[xbus_pkg::PIN_DATA_LSB +: 8]; // [RULE_05]
            end
          end else begin
            strobe_cnt_r <= strobe_cnt_r - 4'h1;
          end
        end
        xbus_pkg::BS_DONE: begin
          bus_r <= xbus_pkg::BS_IDLE;
          o_cpu_busy <= 1'b0;
          o_cpu_rvalid <= ~we_r;
          o_cpu_rdata <= int_data_r;
          o_fetch_indicator <= 1'b0;
          o_addr_oe_n <= 1'b1;
          o_data_oe_n <= 1'b1;
        end
        default: begin
          bus_r <= xbus_pkg::BS_IDLE;
        end
      endcase
    end
  end

  property p_reset_floats;
    @(posedge i_core_clk) rst |=> (o_addr_oe_n && o_data_oe_n && o_bus_write_strobe_n && o_bus_read_strobe_n);
  endproperty
  a_reset_floats: assert property (p_reset_floats) else $error("bus not idle after reset cycle"); // [RULE_01]

  property p_bank_bits;
    @(posedge i_core_clk) disable iff (rst)
      (bus_r == xbus_pkg::BS_IDLE && i_cpu_req && go_ext) |=> (o_addr[15:13] == $past(i_bank_map_bit));
  endproperty
  a_bank_bits: assert property (p_bank_bits) else $error("high address not from bank bits"); // [RULE_02]

  property p_write_strobe;
    @(posedge i_core_clk) disable iff (rst)
      (bus_r == xbus_pkg::BS_IDLE && i_cpu_req && i_cpu_we && go_ext)
        |=> ##1 (!o_bus_write_strobe_n && !o_data_oe_n && o_bus_read_strobe_n)[*3];
  endproperty
  a_write_strobe: assert property (p_write_strobe) else $error("write strobe or data drive missing"); // [RULE_04]

  property p_read_strobe;
    @(posedge i_core_clk) disable iff (rst)
      (bus_r == xbus_pkg::BS_IDLE && i_cpu_req && !i_cpu_we && go_ext)
        |=> o_data_oe_n ##1 (!o_bus_read_strobe_n && o_data_oe_n);
  endproperty
  a_read_strobe: assert property (p_read_strobe) else $error("read strobe missing or data driven"); // [RULE_05]

  property p_normal_hidden;
    @(posedge i_core_clk) disable iff (rst)
      (bus_r == xbus_pkg::BS_IDLE && i_cpu_req && !i_cpu_we && is_internal && emu_normal)
        |=> (o_addr_oe_n && o_bus_read_strobe_n) ##1 (o_cpu_rvalid && o_addr_oe_n);
  endproperty
  a_normal_hidden: assert property (p_normal_hidden) else $error("internal read leaked to bus"); // [RULE_16]

  property p_emu_fetch_ext;
    @(posedge i_core_clk) disable iff (rst)
      (bus_r == xbus_pkg::BS_IDLE && i_cpu_req && !i_cpu_we && i_cpu_progfetch && !emu_normal
       && page >= xbus_pkg::ROM_BASE_PAGE) |=> ##1 !o_bus_read_strobe_n;
  endproperty
  a_emu_fetch_ext: assert property (p_emu_fetch_ext) else $error("emulation fetch not external"); // [RULE_17]

  property p_emu_show_data;
    @(posedge i_core_clk) disable iff (rst)
      (bus_r == xbus_pkg::BS_IDLE && i_cpu_req && !i_cpu_we && !emu_normal
       && page < xbus_pkg::EMU_DATA_PAGE_END) |=> (!o_data_oe_n && o_data == $past(i_internal_rdata));
  endproperty
  a_emu_show_data: assert property (p_emu_show_data) else $error("internal data not shown"); // [RULE_18]

  property p_fetch_flag;
    @(posedge i_core_clk) disable iff (rst)
      (bus_r == xbus_pkg::BS_IDLE && i_cpu_req) |=> (o_fetch_indicator == $past(i_cpu_opfetch));
  endproperty
  a_fetch_flag: assert property (p_fetch_flag) else $error("fetch indicator wrong"); // [RULE_19]

  property p_phase_clock;
    @(posedge i_core_clk) disable iff (rst)
      (!o_bus_read_strobe_n || !o_bus_write_strobe_n) |-> o_bus_phase_clock_out;
  endproperty
  a_phase_clock: assert property (p_phase_clock) else $error("strobe outside bus clock phase"); // [RULE_20]

  property p_nmi_take;
    @(posedge i_core_clk) disable iff (rst)
      (nmi_edge && !i_instr_done) ##1 (i_instr_done && !$past(i_instr_done)) |=> o_nmi_take;
  endproperty
  a_nmi_take: assert property (p_nmi_take) else $error("nmi not taken at instruction end"); // [RULE_07]

  property p_vector_fetch;
    @(posedge i_core_clk) disable iff (i_reset)
      $fell(rst) |-> ##1 o_reset_vector_fetch;
  endproperty
  a_vector_fetch: assert property (p_vector_fetch) else $error("no vector fetch after reset"); // [RULE_06]
endmodule

// ===== logic/pin_sync.sv
// Two-flop synchronisers for asynchronous pins
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Pins
  input wire logic [W-1:0] i_pins,
  output logic [W-1:0] o_sync
);
  initial begin
    if (W < 1) $error("pin_sync needs at least one lane");
  end

  logic [W-1:0] meta_r;

  for (genvar g = 0; g < W; g++) begin : g_lane
    always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
        meta_r[g] <= RESET_VAL[g];
        o_sync[g] <= RESET_VAL[g];
      end else begin
        meta_r[g] <= i_pins[g];
        o_sync[g] <= meta_r[g];
      end
    end
  end
endmodule

// ===== logic/wake_unit.sv
// Sleep and stop state with qualified wake-up conditions
`timescale 1ns/1ns
module wake_unit (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Link to pin logic
  lp_if.unit lp
);
  xbus_pkg::lp_state_t state_r;
  logic [3:0] nmi_cnt_r;
  logic wake_r;
  logic qual;
  logic stop_done;

  // Any enabled condition wakes from either low-power state
  assign qual = (lp.ring & lp.enables[xbus_pkg::RING_WAKE_BIT]) | // [RULE_10]
                (~lp.host_sel_n & ~lp.host_wr_n & lp.enables[xbus_pkg::HOST_WRITE_WAKE_BIT]) | // [RULE_11]
                (~lp.txd & lp.enables[xbus_pkg::SERIAL_START_WAKE_BIT]) | // [RULE_12]
                (~lp.host_sel_n & lp.enables[xbus_pkg::TERMINAL_READY_WAKE_BIT]) | // [RULE_13]
                (~lp.host_wr_n & lp.enables[xbus_pkg::LINE_ALERT_WAKE_BIT]); // [RULE_14]
  // Twelfth consecutive low sample
  assign stop_done = ~lp.nmi_n && (nmi_cnt_r == 4'(xbus_pkg::NMI_STOP_CYCLES - 1)); // [RULE_09]

  assign lp.wake = wake_r;
  assign lp.low_power = (state_r != xbus_pkg::LP_RUN);

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      nmi_cnt_r <= 4'h0;
    end else if (state_r == xbus_pkg::LP_STOP && ~lp.nmi_n && !stop_done) begin
      nmi_cnt_r <= nmi_cnt_r + 4'h1;
    end else begin
      nmi_cnt_r <= 4'h0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_r <= xbus_pkg::LP_RUN;
      wake_r <= 1'b0;
    end else begin
      wake_r <= 1'b0;
      unique case (state_r)
        xbus_pkg::LP_RUN: begin
          if (lp.stop_req) begin
            state_r <= xbus_pkg::LP_STOP;
          end else if (lp.sleep_req) begin
            state_r <= xbus_pkg::LP_SLEEP;
          end
        end
        xbus_pkg::LP_SLEEP: begin
          if (~lp.nmi_n || qual) begin // [RULE_08] [RULE_21]
            state_r <= xbus_pkg::LP_RUN;
            wake_r <= 1'b1;
          end
        end
        xbus_pkg::LP_STOP: begin
          if (stop_done || qual) begin // [RULE_09] [RULE_21]
            state_r <= xbus_pkg::LP_RUN;
            wake_r <= 1'b1;
          end
        end
        default: begin
          state_r <= xbus_pkg::LP_RUN;
        end
      endcase
    end
  end

  property p_sleep_nmi_wake;
    @(posedge i_core_clk) disable iff (i_rst)
      (state_r == xbus_pkg::LP_SLEEP && !lp.nmi_n) |=> (wake_r && state_r == xbus_pkg::LP_RUN);
  endproperty
  a_sleep_nmi_wake: assert property (p_sleep_nmi_wake) else $error("sleep did not wake on low nmi"); // [RULE_08]

  // Separate run length of low nmi samples in stop; saturates so it never wraps onto the trigger value
  logic [3:0] low_run_r;
  always_ff @(posedge i_core_clk) begin
    if (i_rst || state_r != xbus_pkg::LP_STOP || lp.nmi_n) begin
      low_run_r <= 4'h0;
    end else if (low_run_r != 4'hF) begin
      low_run_r <= low_run_r + 4'h1;
    end
  end

  property p_stop_nmi_wake;
    @(posedge i_core_clk) disable iff (i_rst)
      (state_r == xbus_pkg::LP_STOP && !lp.nmi_n && low_run_r == 4'(xbus_pkg::NMI_STOP_CYCLES - 1)) |=> wake_r;
  endproperty
  a_stop_nmi_wake: assert property (p_stop_nmi_wake) else $error("stop did not wake after 12 low cycles"); // [RULE_09]

  property p_stop_no_early;
    @(posedge i_core_clk) disable iff (i_rst)
      (state_r == xbus_pkg::LP_STOP && !qual && nmi_cnt_r < 4'hB) |=> !wake_r;
  endproperty
  a_stop_no_early: assert property (p_stop_no_early) else $error("stop woke before 12 low cycles"); // [RULE_09]

  property p_ring_wake;
    @(posedge i_core_clk) disable iff (i_rst)
      (state_r != xbus_pkg::LP_RUN && lp.ring && lp.enables[xbus_pkg::RING_WAKE_BIT]) |=> wake_r;
  endproperty
  a_ring_wake: assert property (p_ring_wake) else $error("enabled ring did not wake"); // [RULE_10]

  property p_host_write_wake;
    @(posedge i_core_clk) disable iff (i_rst)
      (state_r != xbus_pkg::LP_RUN && !lp.host_sel_n && !lp.host_wr_n
       && lp.enables[xbus_pkg::HOST_WRITE_WAKE_BIT]) |=> (wake_r && state_r == xbus_pkg::LP_RUN);
  endproperty
  a_host_write_wake: assert property (p_host_write_wake) else $error("enabled host write did not wake"); // [RULE_11]

  property p_no_wake_unqualified;
    @(posedge i_core_clk) disable iff (i_rst)
      (state_r == xbus_pkg::LP_SLEEP && lp.nmi_n && !qual) |=> (!wake_r && state_r == xbus_pkg::LP_SLEEP);
  endproperty
  a_no_wake_unqualified: assert property (p_no_wake_unqualified) else $error("woke without a cause"); // [RULE_21]
endmodule

// ===== logic/xbus_pkg.sv
// Constants and types shared by the expansion bus and wake logic
package xbus_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int NMI_STOP_CYCLES = 12;
  localparam int STROBE_CYCLES_DEFAULT = 3;
  localparam int STROBE_CYCLES_MIN = 3;
  localparam int STROBE_CYCLES_MAX = 15;

  // Address map, page is address bits 15..8
  localparam logic [7:0] INTERNAL_PAGE_END = 8'h05;
  localparam logic [7:0] EMU_DATA_PAGE_END = 8'h04;
  localparam logic [7:0] ROM_BASE_PAGE = 8'hE0;
  localparam int BANK_ADDR_LSB = 13;

  // Low-power control bit positions
  localparam int RING_WAKE_BIT = 5;
  localparam int HOST_WRITE_WAKE_BIT = 4;
  localparam int SERIAL_START_WAKE_BIT = 3;
  localparam int TERMINAL_READY_WAKE_BIT = 2;
  localparam int LINE_ALERT_WAKE_BIT = 1;

  // Synchroniser lane positions
  localparam int PIN_RESET = 0;
  localparam int PIN_NMI = 1;
  localparam int PIN_RING = 2;
  localparam int PIN_TXD = 3;
  localparam int PIN_HOST_SEL = 4;
  localparam int PIN_HOST_WR = 5;
  localparam int PIN_EMU = 6;
  localparam int PIN_DATA_LSB = 7;
  localparam int PIN_COUNT = 15;
  localparam logic [PIN_COUNT-1:0] PIN_RESET_VAL = 15'h007B;

  typedef enum logic [2:0] {
    LP_RUN = 3'h1,
    LP_SLEEP = 3'h2,
    LP_STOP = 3'h4
  } lp_state_t;

  typedef enum logic [3:0] {
    BS_IDLE = 4'h1,
    BS_ADDR = 4'h2,
    BS_STROBE = 4'h4,
    BS_DONE = 4'h8
  } bus_state_t;
endpackage

// ===== verif/ext_mem.sv
// Behavioural external memory on the expansion bus
`timescale 1ns/1ns
module ext_mem (
  // Clock
  input wire logic i_core_clk,
  // Bus seen from the memory
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_bus,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  // Data driven by the memory
  output logic [7:0] o_data
);
  logic [7:0] mem [int];
  logic [7:0] last_r = 8'h00;
  function automatic logic [7:0] fetch(input logic [15:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : (a[7:0] ^ a[15:8]);
  endfunction
  // A released bus shows the inverse of the last byte, so stale data never passes
  always @* begin
    o_data = i_rd_n ? ~last_r : fetch(i_addr);
  end
  always @(posedge i_core_clk) begin
    if (!i_rd_n) begin
      last_r <= fetch(i_addr);
    end
    if (!i_wr_n) begin
      mem[int'(i_addr)] = i_bus;
    end
  end
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the expansion bus and wake logic
`timescale 1ns/1ns
module tb_top;
  logic i_core_clk = 0, i_reset = 1, i_reset_in_n = 1, i_cpu_req = 0, i_cpu_we = 0, i_cpu_opfetch = 0;
  logic i_cpu_progfetch = 0, i_instr_done = 0, i_nmi_n = 1, i_sleep_req = 0, i_stop_req = 0;
  logic i_ring_detect_in = 0, i_serial_tx_line = 1, i_host_select_in = 1, i_host_write_in = 1;
  logic i_emulation_select_n = 1;
  logic [15:0] i_cpu_addr = 16'h0000;
  logic [7:0] i_cpu_wdata = 8'h00, i_internal_rdata = 8'h00, i_low_power_control = 8'h00;
  logic [2:0] i_bank_map_bit = 3'h0;
  logic o_cpu_busy, o_cpu_rvalid, o_nmi_take, o_reset_vector_fetch, o_low_power, o_wake, o_rom_enable;
  logic o_fetch_indicator, o_bus_phase_clock_out, o_addr_oe_n, o_data_oe_n;
  logic o_bus_write_strobe_n, o_bus_read_strobe_n;
  logic [15:0] o_addr, a;
  logic [7:0] o_cpu_rdata, o_data, mem_d, rd, shown;
  logic strobed, fetched, drv;
  logic [31:0] seed = 32'h0000001B;
  logic [7:0] ref_mem [int];
  int err_count = 0, cmp_count = 0, n, t;
  // Wire level: the device wins only while its enable is low
  wire [7:0] i_data = o_data_oe_n ? mem_d : o_data;

  mcu_expansion_bus_and_wake #(.STROBE_CYCLES(3)) dut (.i_core_clk, .i_reset, .i_reset_in_n, .i_cpu_req,
    .i_cpu_we, .i_cpu_opfetch, .i_cpu_progfetch, .i_cpu_addr, .i_cpu_wdata, .i_internal_rdata,
    .i_bank_map_bit, .i_instr_done, .o_cpu_busy, .o_cpu_rvalid, .o_cpu_rdata, .i_nmi_n, .o_nmi_take,
    .o_reset_vector_fetch, .i_low_power_control, .i_sleep_req, .i_stop_req, .i_ring_detect_in,
    .i_serial_tx_line, .i_host_select_in, .i_host_write_in, .o_low_power, .o_wake, .i_emulation_select_n,
    .o_rom_enable, .o_fetch_indicator, .o_bus_phase_clock_out, .o_addr, .o_addr_oe_n, .i_data, .o_data,
    .o_data_oe_n, .o_bus_write_strobe_n, .o_bus_read_strobe_n);
  ext_mem u_mem (.i_core_clk, .i_addr(o_addr), .i_bus(i_data), .i_rd_n(o_bus_read_strobe_n),
    .i_wr_n(o_bus_write_strobe_n), .o_data(mem_d));

  initial begin
    forever #5 i_core_clk = ~i_core_clk;
  end

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function logic [7:0] exp_mem(input logic [15:0] x);
    return ref_mem.exists(int'(x)) ? ref_mem[int'(x)] : (x[7:0] ^ x[15:8]);
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask

  task wrap_up();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task cyc(input int k);
    repeat (k) @(posedge i_core_clk);
    #1;
  endtask

  // One access, watched cycle by cycle until the port is idle again
  task acc(input logic we, input logic op, input logic pf, input logic [15:0] ad);
    i_cpu_we = we;
    i_cpu_opfetch = op;
    i_cpu_progfetch = pf;
    i_cpu_addr = ad;
    i_cpu_wdata = 8'(rnd());
    i_internal_rdata = 8'(rnd());
    i_cpu_req = 1;
    {strobed, fetched, drv, shown} = 11'h000;
    cyc(1);
    i_cpu_req = 0;
    for (n = 0; n < 40 && o_cpu_busy; n++) begin
      if (!o_bus_read_strobe_n || !o_bus_write_strobe_n) begin
        strobed = 1;
        chk(o_addr, {i_bank_map_bit, ad[12:0]}, "bank address");
        chk(o_bus_phase_clock_out, 1, "phase clock");
        chk(o_addr_oe_n, 0, "address enable");
      end
      if (!o_data_oe_n) begin
        drv = 1;
        shown = o_data;
      end
      fetched |= o_fetch_indicator;
      cyc(1);
    end
    if (n == 40) begin
      chk(0, 1, "access hang");
      wrap_up();
    end
    rd = o_cpu_rdata;
    chk(o_cpu_rvalid, !we, "read valid");
    // Busy spans strobe length plus address and done cycles on the bus, one cycle when hidden
    chk(n, (strobed || drv) ? 5 : 1, "busy cycles");
    if (we && strobed) ref_mem[int'({i_bank_map_bit, ad[12:0]})] = i_cpu_wdata;
  endtask

  task lp(input logic stp);
    i_stop_req = stp;
    i_sleep_req = !stp;
    cyc(1);
    {i_stop_req, i_sleep_req} = 2'h0;
    cyc(3);
    chk(o_low_power, 1, "low power entry");
  endtask

  task ww(input int lim);
    for (t = 0; t < lim && !o_wake; t++) cyc(1);
  endtask

  initial begin
    cyc(16);
    chk({o_addr_oe_n, o_data_oe_n, o_bus_write_strobe_n, o_bus_read_strobe_n}, 4'hF, "reset");
    i_reset = 0;
    for (n = 0; n < 6 && !o_reset_vector_fetch; n++) cyc(1);
    chk(o_reset_vector_fetch, 1, "vector fetch");
    for (int k = 0; k < 8; k++) begin
      i_bank_map_bit = 3'(rnd());
      a = {8'h05 + 8'(rnd() % 219), 8'(rnd())};
      acc(1, 0, 0, a);
      chk({strobed, fetched, drv, shown}, {3'h5, i_cpu_wdata}, "ext write");
      acc(0, 0, 0, a);
      chk({strobed, drv, rd}, {2'h2, exp_mem({i_bank_map_bit, a[12:0]})}, "ext read");
    end
    for (int p = 0; p < 5; p++) begin
      acc(p[0], 0, 0, {8'(p), 8'(rnd())});
      chk({strobed, drv}, 2'h0, "hidden page");
      if (!p[0]) chk(rd, i_internal_rdata, "internal data");
    end
    acc(0, 0, 1, {8'hE0, 8'(rnd())});
    chk({o_rom_enable, strobed, rd}, {2'h2, i_internal_rdata}, "rom fetch");
    i_emulation_select_n = 0;
    cyc(4);
    chk(o_rom_enable, 0, "rom off");
    a = {8'hE0, 8'(rnd())};
    acc(0, 1, 1, a);
    chk({strobed, fetched, rd}, {2'h3, exp_mem({i_bank_map_bit, a[12:0]})}, "emu fetch");
    acc(0, 0, 0, {8'h02, 8'(rnd())});
    chk({strobed, drv, shown}, {2'h1, i_internal_rdata}, "emu shown");
    i_emulation_select_n = 1;
    cyc(4);
    i_nmi_n = 0;
    cyc(5);
    chk(o_nmi_take, 0, "nmi early");
    i_instr_done = 1;
    cyc(1);
    i_instr_done = 0;
    for (n = 0; n < 4 && !o_nmi_take; n++) cyc(1);
    chk(o_nmi_take, 1, "nmi taken");
    i_nmi_n = 1;
    cyc(4);
    lp(0);
    i_nmi_n = 0;
    ww(8);
    chk(t < 8, 1, "sleep wake");
    i_nmi_n = 1;
    cyc(4);
    chk(o_low_power, 0, "running");
    lp(1);
    i_nmi_n = 0;
    cyc(8);
    i_nmi_n = 1;
    ww(12);
    chk(t, 12, "short low");
    i_nmi_n = 0;
    ww(20);
    chk(t >= 12 && t < 20, 1, "stop wake");
    i_nmi_n = 1;
    cyc(4);
    // Each condition is first shown with its enable clear, so an unqualified wake is caught
    for (int k = 1; k < 6; k++) begin
      lp(k[0]);
      i_ring_detect_in = (k == 5);
      i_serial_tx_line = (k != 3);
      i_host_select_in = !(k == 2 || k == 4);
      i_host_write_in = !(k == 1 || k == 4);
      ww(10);
      chk(t, 10, "wake disabled");
      i_low_power_control = 8'h01 << k;
      ww(8);
      chk(t < 8, 1, "wake enabled");
      {i_ring_detect_in, i_serial_tx_line, i_host_select_in, i_host_write_in} = 4'h7;
      i_low_power_control = 8'h00;
      cyc(4);
      chk(o_low_power, 0, "resumed");
    end
    i_cpu_we = 0;
    i_cpu_addr = 16'h1234;
    i_cpu_req = 1;
    cyc(1);
    i_cpu_req = 0;
    cyc(2);
    i_reset_in_n = 0;
    cyc(4);
    chk({o_addr_oe_n, o_data_oe_n, o_bus_write_strobe_n, o_bus_read_strobe_n}, 4'hF, "pin reset");
    i_reset_in_n = 1;
    for (n = 0; n < 8 && !o_reset_vector_fetch; n++) cyc(1);
    chk(o_reset_vector_fetch, 1, "pin vector");
    wrap_up();
  end
endmodule
